// ---- core/async_serial_extension_ctrl.sv ----
// Extension control of two asynchronous serial channels with a Wishbone register slave.
//
// Notes on behaviour
// - With carrier-detect chosen and carrier auto-enable on, a high carrier input holds receiver 0 in reset.
// - With carrier auto-enable switched off, the carrier input never holds the receiver.
// - The carrier level is always readable in channel 0 status and its rising edge raises the carrier interrupt.
// - With clear-to-send chosen and its auto-enable on, a high clear-to-send input forces channel 0 transmit-empty low.
// - With clear-to-send auto-enable off the input leaves the transmitter alone, and its level is always readable.
// - In single rate mode the baud clock is used directly as the bit clock, the peer syncing data to it.
// - Otherwise the baud clock is divided by 16 or 64 by the divide ratio bit.
// - In prescaler mode the system clock is divided by 10 or 30 and then by two to the speed select.
// - In time constant mode the system clock is divided by twice the sum of the constant and two.
// - With break enable set the receiver reports breaks and the transmitter sends them on command.
// - Break detect sets when an all-zero character with a framing error becomes the oldest entry.
// - Break detect clears on error flag reset, reset, I/O stop, and for channel 0 under carrier hold.
// - Send break with break enable drives the transmit output low for as long as software keeps it.
// - Send break resets to zero, and then the transmit pin carries the normal serial output.
// - Every bit of both extension registers clears on reset.
`timescale 1ns/1ns
module async_serial_extension_ctrl #(
	parameter int unsigned NUM_CHANNELS = async_ext_pkg::NUM_CHANNELS
) (
	input  wire logic                          i_clock,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_wb_cyc,
	input  wire logic                          i_wb_stb,
	input  wire logic                          i_wb_we,
	input  wire logic [7:0]                    i_wb_adr,
	input  wire logic [3:0]                    i_wb_sel,
	input  wire logic [31:0]                   i_wb_dat,
	output logic      [31:0]                   o_wb_dat,
	output logic                               o_wb_ack,
	input  wire logic                          i_carrier_detect_in,
	input  wire logic                          i_clear_to_send_in,
	input  wire logic [NUM_CHANNELS-1:0]       i_async_serial_clock_pin,
	output logic      [NUM_CHANNELS-1:0]       o_async_serial_clock_pin,
	output logic      [NUM_CHANNELS-1:0]       o_async_serial_clock_oe,
	output logic      [NUM_CHANNELS-1:0]       o_async_tx_out,
	input  wire logic [NUM_CHANNELS-1:0]       i_tx_serial,
	input  wire logic [NUM_CHANNELS-1:0]       i_tx_holding_empty_raw,
	output logic      [NUM_CHANNELS-1:0]       o_tx_holding_empty,
	input  async_ext_pkg::rx_char_t [NUM_CHANNELS-1:0] i_rx_char,
	input  wire logic [NUM_CHANNELS-1:0]       i_error_flag_reset,
	output logic                               o_rx0_hold_reset,
	output logic                               o_carrier_rise,
	output async_ext_pkg::clock_ticks_t [NUM_CHANNELS-1:0] o_ticks,
	output logic                               o_irq
);
	localparam int unsigned DW = async_ext_pkg::DIV_WIDTH;
	localparam int unsigned TW = async_ext_pkg::TC_WIDTH;

	generate
		if (NUM_CHANNELS != 2) begin : g_bad_channels
			$error("async_serial_extension_ctrl supports exactly two channels");
		end
	endgenerate

	// Full divisor of the baud generator in system clock cycles.
	function automatic logic [DW-1:0] baud_divisor(input logic [2:0] ss, input logic dr,
		input logic brg, input logic [TW-1:0] tc);
		logic [DW-1:0] pre;
		pre = dr ? async_ext_pkg::PRESCALE_HIGH : async_ext_pkg::PRESCALE_LOW;
		if (brg) begin
			baud_divisor = DW'({2'b00, tc} + async_ext_pkg::TC_OFFSET) << 1;
		end else begin
			baud_divisor = pre << ss;
		end
	endfunction

	// Pin synchroniser: stage one feeds only stage two.
	localparam int unsigned SYNC_W = NUM_CHANNELS + 2;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_async_serial_clock_pin, i_clear_to_send_in, i_carrier_detect_in};
			sync2_q <= sync1_q;
		end
	end

	wire       carrier_s = sync2_q[0];
	wire       cts_s     = sync2_q[1];
	wire [NUM_CHANNELS-1:0] cka_s = sync2_q[SYNC_W-1:2];
	logic      carrier_prev_q;
	logic [NUM_CHANNELS-1:0] cka_prev_q;

	// Software visible registers.
	logic [7:0]    ext_q     [NUM_CHANNELS];
	logic [3:0]    ctrlb_q   [NUM_CHANNELS];
	logic [TW-1:0] tconst_q  [NUM_CHANNELS];
	logic [7:0]    cfg_q;
	logic [async_ext_pkg::IRQ_BITS-1:0] irq_status_q;
	logic [async_ext_pkg::IRQ_BITS-1:0] irq_enable_q;
	logic          break_det_q [NUM_CHANNELS];
	logic [31:0]   rdata_q;
	logic          ack_q;

	// Bus decode.
	wire        bus_req    = i_wb_cyc & i_wb_stb;
	wire        wr_take    = bus_req & i_wb_we & ack_q & i_wb_sel[0];
	wire [7:0]  wdata      = i_wb_dat[7:0];
	wire [15:0] wdata16    = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, wdata};
	wire        wr_ext0    = wr_take & (i_wb_adr == async_ext_pkg::OFF_EXT0);
	wire        wr_ext1    = wr_take & (i_wb_adr == async_ext_pkg::OFF_EXT1);
	wire        wr_ctrlb0  = wr_take & (i_wb_adr == async_ext_pkg::OFF_CTRL_B0);
	wire        wr_ctrlb1  = wr_take & (i_wb_adr == async_ext_pkg::OFF_CTRL_B1);
	wire        wr_tc0     = wr_take & (i_wb_adr == async_ext_pkg::OFF_TCONST0);
	wire        wr_tc1     = wr_take & (i_wb_adr == async_ext_pkg::OFF_TCONST1);
	wire        wr_enable  = wr_take & (i_wb_adr == async_ext_pkg::OFF_IRQ_ENABLE);
	wire        wr_clear   = wr_take & (i_wb_adr == async_ext_pkg::OFF_IRQ_CLEAR);
	wire        wr_cfg     = wr_take & (i_wb_adr == async_ext_pkg::OFF_SYS_CFG);
	wire [NUM_CHANNELS-1:0] wr_ext   = {wr_ext1, wr_ext0};
	wire [NUM_CHANNELS-1:0] wr_ctrlb = {wr_ctrlb1, wr_ctrlb0};
	wire [NUM_CHANNELS-1:0] wr_tc    = {wr_tc1, wr_tc0};
	wire [7:0]  ext_wmask [NUM_CHANNELS];
	assign ext_wmask[0] = async_ext_pkg::EXT0_WMASK;
	assign ext_wmask[1] = async_ext_pkg::EXT1_WMASK;

	// Modem line gating on channel 0.
	wire io_stop      = cfg_q[async_ext_pkg::CFG_IO_STOP];
	wire carrier_auto = ~cfg_q[async_ext_pkg::CFG_EDGE_SEL]
		& ~ext_q[0][async_ext_pkg::EXT_CARRIER_DIS];
	wire carrier_hold = carrier_auto & carrier_s;
	wire cts_hold     = ~cfg_q[async_ext_pkg::CFG_CTS_SEL]
		& ~ext_q[0][async_ext_pkg::EXT_CTS_DIS] & cts_s;
	wire carrier_edge = carrier_s & ~carrier_prev_q;
	assign o_rx0_hold_reset = carrier_hold;
	assign o_carrier_rise   = carrier_edge;
	assign o_tx_holding_empty[0] = i_tx_holding_empty_raw[0] & ~cts_hold;
	assign o_tx_holding_empty[NUM_CHANNELS-1:1] = i_tx_holding_empty_raw[NUM_CHANNELS-1:1];

	// Event sources for the interrupt status.
	wire [NUM_CHANNELS-1:0] break_set;
	wire [NUM_CHANNELS-1:0] break_clr;
	wire [async_ext_pkg::IRQ_BITS-1:0] irq_events = {break_set[1], break_set[0], carrier_edge};
	wire [async_ext_pkg::IRQ_BITS-1:0] irq_clr_mask =
		wr_clear ? wdata[async_ext_pkg::IRQ_BITS-1:0] : '0;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			carrier_prev_q <= 1'b0;
			cka_prev_q     <= '0;
			cfg_q          <= '0;
			irq_status_q   <= '0;
			irq_enable_q   <= '0;
		end else begin
			carrier_prev_q <= carrier_s;
			cka_prev_q     <= cka_s;
			if (wr_cfg) begin
				cfg_q <= wdata & async_ext_pkg::CFG_WMASK;
			end
			if (wr_enable) begin
				irq_enable_q <= wdata[async_ext_pkg::IRQ_BITS-1:0];
			end
			irq_status_q <= (irq_status_q & ~irq_clr_mask) | irq_events;
		end
	end

	assign o_irq = |(irq_status_q & irq_enable_q);

	// Per channel registers, baud generator, bit clock, break logic and transmit output.
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			logic [DW-1:0] baud_cnt_q;
			logic [5:0]    over_cnt_q;
			logic          tx_q;
			logic          clk_out_q;
			wire [2:0]     ss       = ctrlb_q[ch][async_ext_pkg::CTRLB_SS_LSB +: 3];
			wire           dr       = ctrlb_q[ch][async_ext_pkg::CTRLB_DR];
			wire           ext_clk  = (ss == async_ext_pkg::SS_EXTERNAL);
			wire [DW-1:0]  divisor  = baud_divisor(ss, dr,
				ext_q[ch][async_ext_pkg::EXT_BRG_MODE], tconst_q[ch]);
			wire           int_tick = (baud_cnt_q >= divisor - DW'(1));
			wire           cka_rise = cka_s[ch] & ~cka_prev_q[ch];
			wire           baud_tick = ext_clk ? cka_rise : int_tick;
			wire [5:0]     over_max = dr ? async_ext_pkg::OVERSAMPLE_HIGH
				: async_ext_pkg::OVERSAMPLE_LOW;
			wire           single   = ext_q[ch][async_ext_pkg::EXT_SINGLE_RATE];
			wire           over_end = (over_cnt_q >= over_max);
			wire           brk_en   = ext_q[ch][async_ext_pkg::EXT_BREAK_EN];
			wire           send_brk = brk_en & ext_q[ch][async_ext_pkg::EXT_SEND_BREAK];
			wire           rx_zero  = (i_rx_char[ch].data == 8'h00);

			assign break_set[ch] = brk_en & i_rx_char[ch].valid
				& i_rx_char[ch].framing_error & rx_zero;
			assign break_clr[ch] = i_error_flag_reset[ch] | io_stop
				| ((ch == 0) ? carrier_hold : 1'b0);

			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ext_q[ch]    <= async_ext_pkg::EXT_RESET;
					ctrlb_q[ch]  <= async_ext_pkg::CTRLB_RESET;
					tconst_q[ch] <= '0;
					break_det_q[ch] <= 1'b0;
				end else begin
					if (wr_ext[ch]) begin
						ext_q[ch] <= wdata & ext_wmask[ch];
					end
					if (wr_ctrlb[ch]) begin
						ctrlb_q[ch] <= wdata[3:0];
					end
					if (wr_tc[ch]) begin
						tconst_q[ch] <= wdata16;
					end
					// Hold-type clears win; a software clear loses to a new break.
					if (io_stop | ((ch == 0) & carrier_hold)) begin
						break_det_q[ch] <= 1'b0;
					end else if (break_set[ch]) begin
						break_det_q[ch] <= 1'b1;
					end else if (break_clr[ch]) begin
						break_det_q[ch] <= 1'b0;
					end
				end
			end

			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					baud_cnt_q <= '0;
					over_cnt_q <= '0;
					tx_q       <= 1'b1;
					clk_out_q  <= 1'b0;
				end else begin
					baud_cnt_q <= (ext_clk | int_tick) ? '0 : baud_cnt_q + DW'(1);
					clk_out_q  <= (baud_cnt_q < (divisor >> 1));
					if (single) begin
						over_cnt_q <= '0;
					end else if (baud_tick) begin
						over_cnt_q <= over_end ? 6'h00 : over_cnt_q + 6'h01;
					end
					tx_q <= send_brk ? 1'b0 : i_tx_serial[ch];
				end
			end

			assign o_ticks[ch].baud_tick = baud_tick;
			assign o_ticks[ch].bit_tick  = single ? baud_tick : (baud_tick & over_end);
			assign o_async_tx_out[ch]    = tx_q;
			assign o_async_serial_clock_pin[ch] = clk_out_q;
			assign o_async_serial_clock_oe[ch]  = ~ext_clk;
		end
	endgenerate

	// Read multiplexer.
	wire [7:0] ext_rd0 = {ext_q[0][7:2], break_det_q[0], ext_q[0][0]};
	wire [7:0] ext_rd1 = {ext_q[1][7:2], break_det_q[1], ext_q[1][0]};
	wire [7:0] ctrlb_rd0 = {2'b00, cts_s, 1'b0, ctrlb_q[0]};
	wire [7:0] ctrlb_rd1 = {4'h0, ctrlb_q[1]};
	wire [7:0] channel0_status_reg_rd = {5'h00, carrier_s, o_tx_holding_empty[0], 1'b0};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_wb_adr)
			async_ext_pkg::OFF_EXT0:       rd_mux = {24'h00_0000, ext_rd0};
			async_ext_pkg::OFF_EXT1:       rd_mux = {24'h00_0000, ext_rd1};
			async_ext_pkg::OFF_CTRL_B0:    rd_mux = {24'h00_0000, ctrlb_rd0};
			async_ext_pkg::OFF_CTRL_B1:    rd_mux = {24'h00_0000, ctrlb_rd1};
			async_ext_pkg::OFF_TCONST0:    rd_mux = {16'h0000, tconst_q[0]};
			async_ext_pkg::OFF_TCONST1:    rd_mux = {16'h0000, tconst_q[1]};
			async_ext_pkg::OFF_IRQ_STATUS: rd_mux = {29'h0000_0000, irq_status_q};
			async_ext_pkg::OFF_IRQ_ENABLE: rd_mux = {29'h0000_0000, irq_enable_q};
			async_ext_pkg::OFF_SYS_CFG:    rd_mux = {24'h00_0000, cfg_q};
			async_ext_pkg::OFF_STATUS0:    rd_mux = {24'h00_0000, channel0_status_reg_rd};
			default:                       rd_mux = 32'h0000_0000;
		endcase
	end

	// Wishbone answer: ack one cycle after the request, dropped in the next cycle.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req & ~ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdata_q;
endmodule // async_serial_extension_ctrl

// ---- core/async_ext_pkg.sv ----
// Package with register map, field positions and carrier types of the serial extension block.
package async_ext_pkg;
	localparam int unsigned NUM_CHANNELS = 2;
	localparam int unsigned TC_WIDTH     = 16;
	localparam int unsigned DIV_WIDTH    = TC_WIDTH + 2;

	// Word offsets on the register bus (byte addresses).
	localparam logic [7:0] OFF_EXT0       = 8'h00;
	localparam logic [7:0] OFF_EXT1       = 8'h04;
	localparam logic [7:0] OFF_CTRL_B0    = 8'h08;
	localparam logic [7:0] OFF_CTRL_B1    = 8'h0C;
	localparam logic [7:0] OFF_TCONST0    = 8'h10;
	localparam logic [7:0] OFF_TCONST1    = 8'h14;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h20;
	localparam logic [7:0] OFF_SYS_CFG    = 8'h24;
	localparam logic [7:0] OFF_STATUS0    = 8'h28;

	// Extension control register fields.
	localparam int unsigned EXT_CARRIER_DIS = 6;
	localparam int unsigned EXT_CTS_DIS     = 5;
	localparam int unsigned EXT_SINGLE_RATE = 4;
	localparam int unsigned EXT_BRG_MODE    = 3;
	localparam int unsigned EXT_BREAK_EN    = 2;
	localparam int unsigned EXT_BREAK_DET   = 1;
	localparam int unsigned EXT_SEND_BREAK  = 0;
	localparam logic [7:0]  EXT0_WMASK      = 8'h7D;
	localparam logic [7:0]  EXT1_WMASK      = 8'h1D;
	localparam logic [7:0]  EXT_RESET       = 8'h00;

	// Control register B fields: speed select, divide ratio, clear-to-send level.
	localparam int unsigned CTRLB_SS_LSB   = 0;
	localparam int unsigned CTRLB_DR       = 3;
	localparam int unsigned CTRLB_CTS      = 5;
	localparam logic [2:0]  SS_EXTERNAL    = 3'h7;
	localparam logic [3:0]  CTRLB_RESET    = 4'h7;

	// System configuration fields.
	localparam int unsigned CFG_EDGE_SEL   = 0;
	localparam int unsigned CFG_CTS_SEL    = 5;
	localparam int unsigned CFG_IO_STOP    = 7;
	localparam logic [7:0]  CFG_WMASK      = 8'hA1;

	// Channel 0 status fields.
	localparam int unsigned STAT_CARRIER   = 2;
	localparam int unsigned STAT_TX_EMPTY  = 1;

	// Interrupt status bits.
	localparam int unsigned IRQ_CARRIER    = 0;
	localparam int unsigned IRQ_BREAK0     = 1;
	localparam int unsigned IRQ_BREAK1     = 2;
	localparam int unsigned IRQ_BITS       = 3;

	// Clock division figures.
	localparam logic [DIV_WIDTH-1:0] PRESCALE_LOW   = 18'h0_000A;
	localparam logic [DIV_WIDTH-1:0] PRESCALE_HIGH  = 18'h0_001E;
	localparam logic [DIV_WIDTH-1:0] TC_OFFSET      = 18'h0_0002;
	localparam logic [5:0]           OVERSAMPLE_LOW  = 6'h0F;
	localparam logic [5:0]           OVERSAMPLE_HIGH = 6'h3F;

	// Oldest received character as presented by the receive queue.
	typedef struct packed {
		logic       valid;
		logic       framing_error;
		logic [7:0] data;
	} rx_char_t;

	// Per channel clock enables toward the serial engine.
	typedef struct packed {
		logic baud_tick;
		logic bit_tick;
	} clock_ticks_t;
endpackage

// ---- tb/ext_ctrl_monitor.sv ----
// Port-level checks for the serial extension block.
`timescale 1ns/1ns
module ext_ctrl_monitor #(
	parameter int unsigned NUM_CHANNELS = 2
) (
	input wire logic                    i_clock,
	input wire logic                    i_reset_n,
	input wire logic                    i_wb_cyc,
	input wire logic                    i_wb_stb,
	input wire logic                    i_wb_we,
	input wire logic [7:0]              i_wb_adr,
	input wire logic [3:0]              i_wb_sel,
	input wire logic [31:0]             i_wb_dat,
	input wire logic [31:0]             o_wb_dat,
	input wire logic                    o_wb_ack,
	input wire logic                    i_carrier_detect_in,
	input wire logic                    i_clear_to_send_in,
	input wire logic [NUM_CHANNELS-1:0] o_async_tx_out,
	input wire logic [NUM_CHANNELS-1:0] i_tx_serial,
	input wire logic [NUM_CHANNELS-1:0] i_tx_holding_empty_raw,
	input wire logic [NUM_CHANNELS-1:0] o_tx_holding_empty,
	input wire logic                    o_rx0_hold_reset,
	input wire logic                    o_carrier_rise
);
	logic [7:0] ext0_q;
	logic [7:0] cfg_q;
	wire logic wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
	wire logic brk = ext0_q[0] && ext0_q[2];
	wire logic car_auto = !cfg_q[0] && !ext0_q[6];
	wire logic clr_auto = !cfg_q[5] && !ext0_q[5] && !cfg_q[7];
	// Shadows of the gating registers, committed at the same edge as the slave's write.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext0_q <= 8'h00;
			cfg_q <= 8'h00;
		end else if (wr && i_wb_adr == 8'h00) begin
			ext0_q <= i_wb_dat[7:0] & 8'h7D;
		end else if (wr && i_wb_adr == 8'h24) begin
			cfg_q <= i_wb_dat[7:0] & 8'hA1;
		end
	end
	default clocking dc @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered after one cycle");
	rx_hold_a: assert property (i_carrier_detect_in[*4] ##0 car_auto |-> o_rx0_hold_reset)
		else $error("receiver not held while carrier is negated");
	rx_free_a: assert property (ext0_q[6] || cfg_q[0] |-> !o_rx0_hold_reset)
		else $error("receiver held with carrier gating off");
	car_rise_a: assert property ($rose(i_carrier_detect_in) |->
		(##[1:4] o_carrier_rise) or (##[1:4] !i_carrier_detect_in))
		else $error("carrier rise not reported");
	rise_pulse_a: assert property (o_carrier_rise |=> !o_carrier_rise)
		else $error("carrier rise pulse too long");
	send_gate_a: assert property (i_clear_to_send_in[*4] ##0 clr_auto |-> !o_tx_holding_empty[0])
		else $error("transmit empty not forced low");
	send_free_a: assert property (ext0_q[5] && !cfg_q[7] |->
		o_tx_holding_empty[0] == i_tx_holding_empty_raw[0])
		else $error("transmit empty altered with gating off");
	send_brk_a: assert property (brk |=> !o_async_tx_out[0])
		else $error("transmit pin not low during break");
	tx_follow_a: assert property (!brk |=> o_async_tx_out[0] == $past(i_tx_serial[0]))
		else $error("transmit pin does not follow serial output");
	ext_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h00 |->
		(o_wb_dat[7:0] & 8'h7D) == ext0_q)
		else $error("extension register reads wrong value");
	sync_delay_a: assert property (!i_carrier_detect_in[*3] ##1 i_carrier_detect_in |->
		!o_rx0_hold_reset)
		else $error("carrier used before synchronising");
	cover property (o_rx0_hold_reset);
	cover property (brk ##1 !o_async_tx_out[0]);
	cover property (o_carrier_rise);
endmodule // ext_ctrl_monitor

bind async_serial_extension_ctrl ext_ctrl_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) i_ext_ctrl_monitor (
	.i_clock, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
	.o_wb_dat, .o_wb_ack, .i_carrier_detect_in, .i_clear_to_send_in, .o_async_tx_out,
	.i_tx_serial, .i_tx_holding_empty_raw, .o_tx_holding_empty, .o_rx0_hold_reset,
	.o_carrier_rise
);

// ---- tb/serial_peer_model.sv ----
// Remote serial peer driving the modem lines and serial clock pins.
`timescale 1ns/1ns
module serial_peer_model (
	input  wire logic i_clock,
	input  wire logic i_carrier_off,
	input  wire logic i_clr_off,
	input  wire logic i_clock_run,
	output logic      o_carrier_detect_in = 1'b0,
	output logic      o_clear_to_send_in = 1'b0,
	output logic [1:0] o_serial_clock = 2'b00
);
	logic [2:0] phase_q = 3'h0;
	// Modem lines move just after an edge, so they reach the block unsynchronised.
	always @(posedge i_clock) begin
		o_carrier_detect_in <= i_carrier_off;
		o_clear_to_send_in <= i_clr_off;
	end
	// The peer clock runs only on request, with a period of sixteen cycles, and stands still otherwise.
	always @(posedge i_clock) begin
		if (i_clock_run) begin
			phase_q <= phase_q + 3'h1;
			if (phase_q == 3'h7) begin
				o_serial_clock <= ~o_serial_clock;
			end
		end
	end
endmodule // serial_peer_model

// ---- tb/async_serial_extension_ctrl_bench.sv ----
// Self-checking bench for the serial extension block.
`timescale 1ns/1ns
module async_serial_extension_ctrl_bench;
	logic        i_clock = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_wb_cyc = 1'b0;
	logic        i_wb_stb = 1'b0;
	logic        i_wb_we = 1'b0;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [3:0]  i_wb_sel = 4'h3;
	logic [31:0] i_wb_dat = 32'h0000_0000;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	logic        i_carrier_detect_in;
	logic        i_clear_to_send_in;
	logic [1:0]  i_async_serial_clock_pin;
	logic [1:0]  o_async_serial_clock_pin;
	logic [1:0]  o_async_serial_clock_oe;
	logic [1:0]  o_async_tx_out;
	logic [1:0]  i_tx_serial = 2'b11;
	logic [1:0]  i_tx_holding_empty_raw = 2'b11;
	logic [1:0]  o_tx_holding_empty;
	async_ext_pkg::rx_char_t [1:0] i_rx_char = 20'h0_0000;
	logic [1:0]  i_error_flag_reset = 2'b00;
	logic        o_rx0_hold_reset;
	logic        o_carrier_rise;
	async_ext_pkg::clock_ticks_t [1:0] o_ticks;
	logic        o_irq;
	logic        car_off = 1'b0;
	logic        clr_off = 1'b0;
	logic        clk_run = 1'b0;
	logic [31:0] q;
	int          err_total = 0;
	int          num_checks = 0;
	int          cycles = 0;

	async_serial_extension_ctrl #(.NUM_CHANNELS(2)) i_async_serial_extension_ctrl (
		.i_clock, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_carrier_detect_in, .i_clear_to_send_in,
		.i_async_serial_clock_pin, .o_async_serial_clock_pin, .o_async_serial_clock_oe,
		.o_async_tx_out, .i_tx_serial, .i_tx_holding_empty_raw, .o_tx_holding_empty,
		.i_rx_char, .i_error_flag_reset, .o_rx0_hold_reset, .o_carrier_rise, .o_ticks, .o_irq
	);
	serial_peer_model i_serial_peer_model (
		.i_clock, .i_carrier_off(car_off), .i_clr_off(clr_off), .i_clock_run(clk_run),
		.o_carrier_detect_in(i_carrier_detect_in), .o_clear_to_send_in(i_clear_to_send_in),
		.o_serial_clock(i_async_serial_clock_pin)
	);

	initial begin
		forever #4 i_clock = ~i_clock;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_sel <= 4'h3;
		i_wb_adr <= a;
		i_wb_dat <= {24'h00_0000, d};
		do begin
			@(posedge i_clock);
		end while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic pulse_rx(input int c, input logic [9:0] v);
		@(posedge i_clock);
		i_rx_char[c] <= v;
		@(posedge i_clock);
		i_rx_char[c] <= 10'h000;
	endtask
	task automatic t_regs();
		wb(1'b0, 8'h00, 8'h00);
		chk("ext0 reset", q[7:0], 8'h00);
		wb(1'b0, 8'h04, 8'h00);
		chk("ext1 reset", q[7:0], 8'h00);
		wb(1'b1, 8'h00, 8'hFF);
		wb(1'b1, 8'h04, 8'hFF);
		wb(1'b0, 8'h00, 8'h00);
		chk("ext0 rw", q[7:0], 8'h7D);
		wb(1'b0, 8'h04, 8'h00);
		chk("ext1 rw", q[7:0], 8'h1D);
		wb(1'b1, 8'h2C, 8'hFF);
		wb(1'b0, 8'h2C, 8'h00);
		chk("unmapped", q[7:0], 8'h00);
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h04, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_car();
		@(posedge i_clock);
		car_off <= 1'b1;
		wait_n(6);
		chk("rx hold", 8'(o_rx0_hold_reset), 8'h01);
		wb(1'b0, 8'h28, 8'h00);
		chk("carrier level", 8'(q[2]), 8'h01);
		wb(1'b0, 8'h18, 8'h00);
		chk("carrier irq", 8'(q[0]), 8'h01);
		wb(1'b1, 8'h1C, 8'h07);
		wait_n(1);
		chk("irq on", 8'(o_irq), 8'h01);
		wb(1'b1, 8'h20, 8'h01);
		wait_n(1);
		chk("irq off", 8'(o_irq), 8'h00);
		wb(1'b1, 8'h24, 8'h01);
		wait_n(1);
		chk("rx pin other use", 8'(o_rx0_hold_reset), 8'h00);
		wb(1'b1, 8'h24, 8'h00);
		wb(1'b1, 8'h00, 8'h40);
		wait_n(1);
		chk("rx free", 8'(o_rx0_hold_reset), 8'h00);
		wb(1'b1, 8'h00, 8'h00);
		car_off <= 1'b0;
		wait_n(6);
		chk("rx run", 8'(o_rx0_hold_reset), 8'h00);
		$display("test carrier done");
	endtask
	task automatic t_send();
		@(posedge i_clock);
		clr_off <= 1'b1;
		wait_n(6);
		chk("tx empty gated", 8'(o_tx_holding_empty), 8'h02);
		wb(1'b0, 8'h08, 8'h00);
		chk("send level", 8'(q[5]), 8'h01);
		wb(1'b1, 8'h24, 8'h20);
		wait_n(1);
		chk("tx empty pin other use", 8'(o_tx_holding_empty), 8'h03);
		wb(1'b1, 8'h24, 8'h00);
		wb(1'b1, 8'h00, 8'h20);
		wait_n(1);
		chk("tx empty free", 8'(o_tx_holding_empty), 8'h03);
		wb(1'b1, 8'h00, 8'h00);
		clr_off <= 1'b0;
		$display("test send gating done");
	endtask
	task automatic t_brk();
		wb(1'b1, 8'h00, 8'h05);
		wait_n(2);
		chk("break low", 8'(o_async_tx_out), 8'h02);
		wb(1'b1, 8'h00, 8'h04);
		i_tx_serial <= 2'b01;
		wait_n(3);
		chk("tx follow", 8'(o_async_tx_out), 8'h01);
		@(posedge i_clock);
		i_tx_serial <= 2'b11;
		for (int c = 0; c < 2; c++) begin
			wb(1'b1, 8'(4 * c), 8'h04);
			pulse_rx(c, 10'h301);
			wb(1'b0, 8'(4 * c), 8'h00);
			chk("no break", 8'(q[1]), 8'h00);
			pulse_rx(c, 10'h300);
			wb(1'b0, 8'(4 * c), 8'h00);
			chk("break set", 8'(q[1]), 8'h01);
			wb(1'b0, 8'h18, 8'h00);
			chk("break irq", 8'(q[1 + c]), 8'h01);
			@(posedge i_clock);
			i_error_flag_reset[c] <= 1'b1;
			@(posedge i_clock);
			i_error_flag_reset[c] <= 1'b0;
			wb(1'b0, 8'(4 * c), 8'h00);
			chk("break clear", 8'(q[1]), 8'h00);
		end
		pulse_rx(1, 10'h300);
		wb(1'b0, 8'h04, 8'h00);
		chk("break again", 8'(q[1]), 8'h01);
		wb(1'b1, 8'h24, 8'h80);
		wb(1'b0, 8'h04, 8'h00);
		chk("stop clears", 8'(q[1]), 8'h00);
		wb(1'b1, 8'h24, 8'h00);
		wb(1'b1, 8'h20, 8'h07);
		$display("test break done");
	endtask
	task automatic t_ticks();
		logic [7:0] cb [6] = '{8'h00, 8'h08, 8'h01, 8'h00, 8'h00, 8'h07};
		logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 8'h10};
		int div, bd, nb, nt, nc;
		logic pc;
		wb(1'b1, 8'h10, 8'h01);
		clk_run <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			wb(1'b1, 8'h08, cb[k]);
			wb(1'b1, 8'h00, ex[k]);
			div = ex[k][3] ? 2 * (1 + 2) : (cb[k][3] ? 30 : 10) << cb[k][2:0];
			// An external clock runs at the peer's period of sixteen cycles.
			if (cb[k][2:0] == 3'h7) div = 16;
			bd = ex[k][4] ? 1 : (cb[k][3] ? 64 : 16);
			nb = 0;
			nt = 0;
			nc = 0;
			wait_n(div * bd);
			pc = o_async_serial_clock_pin[0];
			repeat (2 * div * bd) begin
				@(posedge i_clock);
				if (o_ticks[0].baud_tick === 1'b1) nb++;
				if (o_ticks[0].bit_tick === 1'b1) nt++;
				if (o_async_serial_clock_oe[0] === 1'b1 && o_async_serial_clock_pin[0] === 1'b1
					&& pc === 1'b0) nc++;
				pc = o_async_serial_clock_pin[0];
			end
			chk("baud ticks", 8'(nb), 8'(2 * bd));
			chk("bit ticks", 8'(nt), 8'h02);
			chk("clock drive", 8'(o_async_serial_clock_oe[0]), 8'(cb[k][2:0] != 3'h7));
			chk("clock pin rises", 8'(nc), 8'((cb[k][2:0] == 3'h7) ? 0 : 2 * bd));
		end
		clk_run <= 1'b0;
		$display("test ticks done");
	endtask
	task automatic t_reset();
		wb(1'b1, 8'h00, 8'h7D);
		wb(1'b1, 8'h04, 8'h1D);
		@(posedge i_clock);
		i_reset_n <= 1'b0;
		wait_n(3);
		@(posedge i_clock);
		i_reset_n <= 1'b1;
		wait_n(2);
		wb(1'b0, 8'h00, 8'h00);
		chk("ext0 cleared", q[7:0], 8'h00);
		wb(1'b0, 8'h04, 8'h00);
		chk("ext1 cleared", q[7:0], 8'h00);
		$display("test reset done");
	endtask
	initial begin
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'b1;
		wait_n(2);
		t_regs();
		t_car();
		t_send();
		t_brk();
		t_ticks();
		t_reset();
		complete_run();
	end
endmodule // async_serial_extension_ctrl_bench
